//--- src/vmdc_ctrl.sv
// Purpose: Volume ramp, auto-mute gating and primary dither gain control bank
// Assumes: Inputs synchronous to clk_sys_in; fs_tick_in is one cycle per audio sample
// Notes:   Volume code 0x00 loudest, 0xff mute, one code per 0.5 dB
//
// What this block does
// - Emergency settings only on clock error/power loss
// - Emergency pace: 1, 2, 4 samples or instant
// - Emergency step: 4, 2, 1, 0.5 dB
// - Link bit: independent or joint auto-mute
// - Zero-run length comes from separate setting
// - Bit 1 enables right channel auto-mute
// - Bit 0 enables left channel auto-mute
// - Linked and one disabled: never mute other
// - Left primary AC dither gain, bits 7-6
// - Right primary AC dither gain, bits 5-4
// - Left primary DEM dither gain, bits 3-2
// - Right primary DEM dither gain, bits 1-0
// - Soft mute/unmute use normal ramp settings
`timescale 1ns/1ps
`include "vmdc_defs.svh"

module vmdc_ctrl (
  input  wire logic                       clk_sys_in,
  input  wire logic                       rst_in,
  input  wire logic [`VMDC_ADDR_W-1:0]    reg_addr_in,
  input  wire logic [`VMDC_DATA_W-1:0]    reg_wdata_in,
  input  wire logic                       reg_wr_in,
  input  wire logic                       reg_rd_in,
  output logic      [`VMDC_DATA_W-1:0]    reg_rdata_out,
  input  wire logic                       fs_tick_in,
  input  wire logic                       clk_err_in,
  input  wire logic                       power_loss_in,
  input  wire logic                       soft_mute_pin_n_in,
  input  wire logic                       soft_mute_reg_in,
  input  wire logic [`VMDC_DATA_W-1:0]    normal_ramp_cfg_in,
  input  wire logic [`VMDC_DATA_W-1:0]    vol_target_in,
  input  wire logic                       zero_run_l_in,
  input  wire logic                       zero_run_r_in,
  output logic      [`VMDC_DATA_W-1:0]    vol_out,
  output vmdc_pkg::vmdc_mode_t            ramp_mode_out,
  output logic                            auto_mute_l_out,
  output logic                            auto_mute_r_out,
  output vmdc_pkg::vmdc_dither_t          dither_gain_out
);

  // ********************************
  // Register file
  // ********************************
  logic [`VMDC_DATA_W-1:0] emerg_ramp_ctrl_q;
  logic [`VMDC_DATA_W-1:0] emerg_ramp_ctrl_d;
  logic [`VMDC_DATA_W-1:0] auto_mute_ctrl_q;
  logic [`VMDC_DATA_W-1:0] auto_mute_ctrl_d;
  logic [`VMDC_DATA_W-1:0] primary_dither_gain_q;
  logic [`VMDC_DATA_W-1:0] primary_dither_gain_d;
  logic [`VMDC_DATA_W-1:0] rdata_q;
  logic [`VMDC_DATA_W-1:0] rdata_d;
  // Status state is read back here, so it is declared ahead of the decoder
  vmdc_pkg::vmdc_mode_t    ramp_mode_q;
  logic [`VMDC_DATA_W-1:0] vol_q;
  logic                    auto_mute_l_q;
  logic                    auto_mute_r_q;

  always_comb begin
    emerg_ramp_ctrl_d     = emerg_ramp_ctrl_q;
    auto_mute_ctrl_d      = auto_mute_ctrl_q;
    primary_dither_gain_d = primary_dither_gain_q;
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        `VMDC_OFF_EMERG_RAMP: begin
          emerg_ramp_ctrl_d = reg_wdata_in;
        end
        `VMDC_OFF_AUTO_MUTE: begin
          auto_mute_ctrl_d = reg_wdata_in;
        end
        // Reserved DEM codes are stored as written; software keeps them out
        `VMDC_OFF_PRI_DITHER: begin
          primary_dither_gain_d = reg_wdata_in;
        end
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    rdata_d = 8'h00;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        `VMDC_OFF_EMERG_RAMP: begin
          rdata_d = emerg_ramp_ctrl_q;
        end
        `VMDC_OFF_AUTO_MUTE: begin
          rdata_d = auto_mute_ctrl_q;
        end
        `VMDC_OFF_PRI_DITHER: begin
          rdata_d = primary_dither_gain_q;
        end
        `VMDC_OFF_RAMP_STAT: begin
          rdata_d = {4'h0, ramp_mode_q, auto_mute_r_q, auto_mute_l_q};
        end
        `VMDC_OFF_VOL_STAT: begin
          rdata_d = vol_q;
        end
        default: begin
          rdata_d = 8'h00;
        end
      endcase
    end
  end

  // ********************************
  // Ramp mode selection
  // ********************************
  logic                 emerg_req;
  logic                 soft_mute_req;
  vmdc_pkg::vmdc_mode_t ramp_mode_d;
  vmdc_pkg::vmdc_ramp_t ramp_sel;
  logic [`VMDC_DATA_W-1:0] vol_d;
  logic [`VMDC_DATA_W-1:0] vol_goal;

  assign emerg_req     = clk_err_in | power_loss_in;
  assign soft_mute_req = ~soft_mute_pin_n_in | soft_mute_reg_in;

  // Emergency outranks soft mute: a dying clock must not wait on a slow ramp
  always_comb begin
    if (emerg_req) begin
      ramp_mode_d = vmdc_pkg::VMDC_MODE_EMERG;
    end else if (soft_mute_req) begin
      ramp_mode_d = vmdc_pkg::VMDC_MODE_MUTE;
    end else if (vol_q == vol_target_in) begin
      ramp_mode_d = vmdc_pkg::VMDC_MODE_HOLD;
    end else begin
      ramp_mode_d = vmdc_pkg::VMDC_MODE_PLAY;
    end
  end

  always_comb begin
    vol_goal = vol_target_in;
    ramp_sel = '{pace: normal_ramp_cfg_in[`VMDC_NORM_UP_PACE_HI:`VMDC_NORM_UP_PACE_LO],
                 step: normal_ramp_cfg_in[`VMDC_NORM_UP_STEP_HI:`VMDC_NORM_UP_STEP_LO]};
    unique case (ramp_mode_d)
      vmdc_pkg::VMDC_MODE_EMERG: begin
        vol_goal = `VMDC_VOL_MUTE;
        ramp_sel = '{pace: emerg_ramp_ctrl_q[`VMDC_EMERG_PACE_HI:`VMDC_EMERG_PACE_LO],
                     step: emerg_ramp_ctrl_q[`VMDC_EMERG_STEP_HI:`VMDC_EMERG_STEP_LO]};
      end
      vmdc_pkg::VMDC_MODE_MUTE: begin
        vol_goal = `VMDC_VOL_MUTE;
        ramp_sel = '{pace: normal_ramp_cfg_in[`VMDC_NORM_DN_PACE_HI:`VMDC_NORM_DN_PACE_LO],
                     step: normal_ramp_cfg_in[`VMDC_NORM_DN_STEP_HI:`VMDC_NORM_DN_STEP_LO]};
      end
      vmdc_pkg::VMDC_MODE_PLAY, vmdc_pkg::VMDC_MODE_HOLD: begin
        // Quieter target uses the down settings, louder the up settings
        if (vol_target_in > vol_q) begin
          ramp_sel = '{pace: normal_ramp_cfg_in[`VMDC_NORM_DN_PACE_HI:`VMDC_NORM_DN_PACE_LO],
                       step: normal_ramp_cfg_in[`VMDC_NORM_DN_STEP_HI:`VMDC_NORM_DN_STEP_LO]};
        end
      end
    endcase
  end

  // ********************************
  // Volume pacing and stepping
  // ********************************
  logic [1:0]              pace_cnt_q;
  logic [1:0]              pace_cnt_d;
  logic [2:0]              pace_period;
  logic                    update_now;
  logic [`VMDC_DATA_W-1:0] step_size;
  logic [`VMDC_DATA_W:0]   vol_up_sum;
  logic [`VMDC_DATA_W-1:0] vol_dn_diff;

  // Periods of 1, 2 and 4 sample ticks per update
  assign pace_period = 3'h1 << ramp_sel.pace;
  // Step codes 00..11 give 8, 4, 2, 1 half-dB codes
  assign step_size   = `VMDC_STEP_4DB >> ramp_sel.step;
  assign update_now  = fs_tick_in & ({1'b0, pace_cnt_q} + 3'h1 >= pace_period);
  assign vol_up_sum  = {1'b0, vol_q} + {1'b0, step_size};
  assign vol_dn_diff = vol_q - step_size;

  always_comb begin
    pace_cnt_d = pace_cnt_q;
    vol_d      = vol_q;
    if (ramp_mode_d != ramp_mode_q) begin
      // A new ramp restarts its pacing from a full period
      pace_cnt_d = 2'h0;
    end else if (fs_tick_in) begin
      pace_cnt_d = update_now ? 2'h0 : pace_cnt_q + 2'h1;
    end
    if (ramp_sel.pace == `VMDC_PACE_INSTANT) begin
      vol_d = vol_goal;
    end else if (update_now) begin
      if (vol_q < vol_goal) begin
        // Last step clamps at the goal, never wrapping past mute
        if (vol_up_sum >= {1'b0, vol_goal}) begin
          vol_d = vol_goal;
        end else begin
          vol_d = vol_up_sum[`VMDC_DATA_W-1:0];
        end
      end else if (vol_q > vol_goal) begin
        if ((vol_q < step_size) || (vol_dn_diff <= vol_goal)) begin
          vol_d = vol_goal;
        end else begin
          vol_d = vol_dn_diff;
        end
      end
    end
  end

  // ********************************
  // Auto-mute gating
  // ********************************
  logic auto_mute_l_d;
  logic auto_mute_r_d;
  logic am_link;
  logic am_en_r;
  logic am_en_l;

  // Zero-run inputs are already qualified by the separate duration setting
  assign am_link = auto_mute_ctrl_q[`VMDC_AM_LINK_BIT];
  assign am_en_r = auto_mute_ctrl_q[`VMDC_AM_EN_B1_BIT];
  assign am_en_l = auto_mute_ctrl_q[`VMDC_AM_EN_B0_BIT];

  always_comb begin
    if (am_link) begin
      // Joint mute needs both channels enabled and both zero
      auto_mute_l_d = am_en_l & am_en_r & zero_run_l_in & zero_run_r_in;
      auto_mute_r_d = auto_mute_l_d;
    end else begin
      auto_mute_l_d = am_en_l & zero_run_l_in;
      auto_mute_r_d = am_en_r & zero_run_r_in;
    end
  end

  // ********************************
  // State registers
  // ********************************
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      emerg_ramp_ctrl_q     <= `VMDC_RST_EMERG_RAMP;
      auto_mute_ctrl_q      <= `VMDC_RST_AUTO_MUTE;
      primary_dither_gain_q <= `VMDC_RST_PRI_DITHER;
      rdata_q               <= 8'h00;
      ramp_mode_q           <= vmdc_pkg::VMDC_MODE_PLAY;
      pace_cnt_q            <= 2'h0;
      vol_q                 <= `VMDC_RST_VOLUME;
      auto_mute_l_q         <= 1'b0;
      auto_mute_r_q         <= 1'b0;
    end else begin
      emerg_ramp_ctrl_q     <= emerg_ramp_ctrl_d;
      auto_mute_ctrl_q      <= auto_mute_ctrl_d;
      primary_dither_gain_q <= primary_dither_gain_d;
      rdata_q               <= rdata_d;
      ramp_mode_q           <= ramp_mode_d;
      pace_cnt_q            <= pace_cnt_d;
      vol_q                 <= vol_d;
      auto_mute_l_q         <= auto_mute_l_d;
      auto_mute_r_q         <= auto_mute_r_d;
    end
  end

  // ********************************
  // Outputs
  // ********************************
  assign reg_rdata_out   = rdata_q;
  assign vol_out         = vol_q;
  assign ramp_mode_out   = ramp_mode_q;
  assign auto_mute_l_out = auto_mute_l_q;
  assign auto_mute_r_out = auto_mute_r_q;
  assign dither_gain_out = vmdc_pkg::vmdc_dither_t'(primary_dither_gain_q);

endmodule // vmdc_ctrl

//--- src/vmdc_defs.svh
// Purpose: Offsets, field positions, reset values and volume/pacing codes of the volume/mute/dither control bank
// Assumes: 8-bit register bus, byte offsets
// Notes:   Definitions only
`ifndef VMDC_DEFS_SVH
`define VMDC_DEFS_SVH

// ********************************
// Register offsets
// ********************************
`define VMDC_ADDR_W          8
`define VMDC_DATA_W          8
`define VMDC_OFF_EMERG_RAMP  8'h40
`define VMDC_OFF_AUTO_MUTE   8'h41
`define VMDC_OFF_PRI_DITHER  8'h43
`define VMDC_OFF_RAMP_STAT   8'h4e
`define VMDC_OFF_VOL_STAT    8'h4f

// ********************************
// Reset values
// ********************************
`define VMDC_RST_EMERG_RAMP  8'h10
`define VMDC_RST_AUTO_MUTE   8'h07
`define VMDC_RST_PRI_DITHER  8'h00
`define VMDC_RST_VOLUME      8'hff

// ********************************
// Field positions
// ********************************
`define VMDC_EMERG_PACE_HI   7
`define VMDC_EMERG_PACE_LO   6
`define VMDC_EMERG_STEP_HI   5
`define VMDC_EMERG_STEP_LO   4
`define VMDC_AM_LINK_BIT     2
`define VMDC_AM_EN_B1_BIT    1
`define VMDC_AM_EN_B0_BIT    0
`define VMDC_AM_USED_MASK    8'h07
`define VMDC_NORM_DN_PACE_HI 7
`define VMDC_NORM_DN_PACE_LO 6
`define VMDC_NORM_DN_STEP_HI 5
`define VMDC_NORM_DN_STEP_LO 4
`define VMDC_NORM_UP_PACE_HI 3
`define VMDC_NORM_UP_PACE_LO 2
`define VMDC_NORM_UP_STEP_HI 1
`define VMDC_NORM_UP_STEP_LO 0

// ********************************
// Volume codes and pacing
// ********************************
`define VMDC_VOL_MUTE        8'hff
`define VMDC_PACE_INSTANT    2'h3
`define VMDC_STEP_4DB        8'h08

`endif

//--- src/vmdc_pkg.sv
// Purpose: Types shared by the volume/mute/dither control bank
// Assumes: Constants live in vmdc_defs.svh
// Notes:   Nothing here is imported
package vmdc_pkg;

  typedef enum logic [1:0] {
    VMDC_MODE_PLAY  = 2'b00,
    VMDC_MODE_EMERG = 2'b01,
    VMDC_MODE_MUTE  = 2'b10,
    VMDC_MODE_HOLD  = 2'b11
  } vmdc_mode_t;

  typedef struct packed {
    logic [1:0] left_pri_ac_dither_gain;
    logic [1:0] right_pri_ac_dither_gain;
    logic [1:0] left_pri_dem_dither_gain;
    logic [1:0] right_pri_dem_dither_gain;
  } vmdc_dither_t;

  typedef struct packed {
    logic [1:0] pace;
    logic [1:0] step;
  } vmdc_ramp_t;

endpackage

//--- verification/vmdc_asserts.sv
// Purpose: Port checker for vmdc_ctrl
// Assumes: Shadows of 0x40/0x41 kept from bus writes
// Notes:   Bound at foot of file
`timescale 1ns/1ps
`include "vmdc_defs.svh"
module vmdc_asserts (
  input wire logic                 clk_sys_in,
  input wire logic                 rst_in,
  input wire logic [7:0]           reg_addr_in,
  input wire logic [7:0]           reg_wdata_in,
  input wire logic                 reg_wr_in,
  input wire logic                 reg_rd_in,
  input wire logic [7:0]           reg_rdata_out,
  input wire logic                 fs_tick_in,
  input wire logic                 clk_err_in,
  input wire logic                 power_loss_in,
  input wire logic                 soft_mute_pin_n_in,
  input wire logic                 soft_mute_reg_in,
  input wire logic                 zero_run_l_in,
  input wire logic                 zero_run_r_in,
  input wire logic [7:0]           vol_out,
  input vmdc_pkg::vmdc_mode_t      ramp_mode_out,
  input wire logic                 auto_mute_l_out,
  input wire logic                 auto_mute_r_out,
  input vmdc_pkg::vmdc_dither_t    dither_gain_out
);
  logic [7:0] ramp_q;
  logic [7:0] am_q;
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ramp_q <= `VMDC_RST_EMERG_RAMP;
      am_q   <= `VMDC_RST_AUTO_MUTE;
    end else if (reg_wr_in) begin
      if (reg_addr_in == `VMDC_OFF_EMERG_RAMP) ramp_q <= reg_wdata_in;
      if (reg_addr_in == `VMDC_OFF_AUTO_MUTE) am_q <= reg_wdata_in;
    end
  end
  // Next emergency volume, clamped at mute
  wire       emg  = clk_err_in | power_loss_in;
  wire [8:0] sum  = {1'b0, vol_out} + (9'h008 >> ramp_q[5:4]);
  wire [7:0] nxt  = sum[8] ? 8'hff : sum[7:0];
  wire       both = (&am_q[1:0]) & zero_run_l_in & zero_run_r_in;
  wire       el   = am_q[2] ? both : am_q[0] & zero_run_l_in;
  wire       er   = am_q[2] ? both : am_q[1] & zero_run_r_in;
  wire       emd  = emg && ramp_mode_out == vmdc_pkg::VMDC_MODE_EMERG && !reg_wr_in;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  property p_emerg_mode; emg |=> ramp_mode_out == vmdc_pkg::VMDC_MODE_EMERG; endproperty
  a_emerg_mode: assert property (p_emerg_mode) else $error("no emergency mode");
  property p_soft; !emg && (!soft_mute_pin_n_in || soft_mute_reg_in) |=> ramp_mode_out == vmdc_pkg::VMDC_MODE_MUTE;
  endproperty
  a_soft: assert property (p_soft) else $error("no soft mute mode");
  property p_instant; emd && ramp_q[7:6] == 2'h3 |=> vol_out == 8'hff; endproperty
  a_instant: assert property (p_instant) else $error("instant mute missed");
  property p_step; emd && fs_tick_in && ramp_q[7:6] == 2'h0 |=> vol_out == $past(nxt); endproperty
  a_step: assert property (p_step) else $error("emergency step wrong");
  property p_hold; emd && !fs_tick_in && ramp_q[7:6] != 2'h3 |=> $stable(vol_out); endproperty
  a_hold: assert property (p_hold) else $error("volume moved off tick");
  property p_am; !reg_wr_in |=> auto_mute_l_out == $past(el) && auto_mute_r_out == $past(er); endproperty
  a_am: assert property (p_am) else $error("auto mute wrong");
  property p_dith_wr; reg_wr_in && reg_addr_in == `VMDC_OFF_PRI_DITHER |=> dither_gain_out == $past(reg_wdata_in);
  endproperty
  a_dith_wr: assert property (p_dith_wr) else $error("dither write lost");
  property p_dith_rd; reg_rd_in && reg_addr_in == `VMDC_OFF_PRI_DITHER |=> reg_rdata_out == $past(dither_gain_out);
  endproperty
  a_dith_rd: assert property (p_dith_rd) else $error("dither readback wrong");
  property p_rd_idle; !reg_rd_in |=> reg_rdata_out == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
endmodule // vmdc_asserts
bind vmdc_ctrl vmdc_asserts u_asserts (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .fs_tick_in(fs_tick_in), .clk_err_in(clk_err_in), .power_loss_in(power_loss_in),
  .soft_mute_pin_n_in(soft_mute_pin_n_in), .soft_mute_reg_in(soft_mute_reg_in), .zero_run_l_in(zero_run_l_in),
  .zero_run_r_in(zero_run_r_in), .vol_out(vol_out), .ramp_mode_out(ramp_mode_out),
  .auto_mute_l_out(auto_mute_l_out), .auto_mute_r_out(auto_mute_r_out), .dither_gain_out(dither_gain_out));

//--- verification/volume_mute_dither_ctrl_tb.sv
// Purpose: Self-checking bench for vmdc_ctrl
// Assumes: Target 0x00, normal ramp instant both ways
// Notes:   Fixed normal ramp keeps emergency timing isolated
`timescale 1ns/1ps
`include "vmdc_defs.svh"
module volume_mute_dither_ctrl_tb;
  logic clk_sys_in = 1'b0, rst_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0, fs_tick_in = 1'b0;
  logic clk_err_in = 1'b0, power_loss_in = 1'b0, smp_n = 1'b1, smr = 1'b0, zl = 1'b0, zr = 1'b0;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, rdata, vol;
  logic aml, amr;
  vmdc_pkg::vmdc_mode_t mode;
  vmdc_pkg::vmdc_dither_t dith;
  int miscompares = 0, num_checks = 0;
  vmdc_ctrl u_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(rdata),
    .fs_tick_in(fs_tick_in), .clk_err_in(clk_err_in), .power_loss_in(power_loss_in),
    .soft_mute_pin_n_in(smp_n), .soft_mute_reg_in(smr), .normal_ramp_cfg_in(8'hcf), .vol_target_in(8'h00),
    .zero_run_l_in(zl), .zero_run_r_in(zr), .vol_out(vol), .ramp_mode_out(mode),
    .auto_mute_l_out(aml), .auto_mute_r_out(amr), .dither_gain_out(dith));
  initial forever #25 clk_sys_in = ~clk_sys_in;
  // ********************************
  // Bus and compare helpers
  // ********************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic give_verdict();
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ********************************
  // Scenarios
  // ********************************
  task automatic t_regs();
    rd(`VMDC_OFF_EMERG_RAMP, `VMDC_RST_EMERG_RAMP);
    rd(`VMDC_OFF_AUTO_MUTE, `VMDC_RST_AUTO_MUTE);
    wr(8'h42, 8'h5a);
    rd(8'h42, 8'h00);
    wr(`VMDC_OFF_EMERG_RAMP, 8'ha5);
    rd(`VMDC_OFF_EMERG_RAMP, 8'ha5);
  endtask
  task automatic t_dither();
    logic [7:0] v [4] = '{8'h55, 8'h11, 8'h44, 8'h00};
    chk(dith, `VMDC_RST_PRI_DITHER);
    foreach (v[i]) begin
      wr(`VMDC_OFF_PRI_DITHER, v[i]);
      #1 chk(dith, v[i]);
      rd(`VMDC_OFF_PRI_DITHER, v[i]);
    end
  endtask
  task automatic t_automute();
    logic el, er;
    for (int i = 0; i < 32; i++) begin
      wr(`VMDC_OFF_AUTO_MUTE, {5'h00, i[4:2]});
      zl <= i[0];
      zr <= i[1];
      cyc(2);
      el = i[4] ? &i[3:0] : i[2] & i[0];
      er = i[4] ? &i[3:0] : i[3] & i[1];
      chk({aml, amr}, {el, er});
    end
  endtask
  task automatic t_soft();
    wr(`VMDC_OFF_EMERG_RAMP, 8'h30);
    for (int i = 0; i < 2; i++) begin
      if (i == 0) smp_n <= 1'b0;
      else smr <= 1'b1;
      cyc(3);
      chk(vol, 8'hff);
      chk(mode, vmdc_pkg::VMDC_MODE_MUTE);
      smp_n <= 1'b1;
      smr <= 1'b0;
      cyc(3);
      chk(vol, 8'h00);
    end
  endtask
  task automatic t_emerg();
    int n, s;
    for (int p = 0; p < 4; p++) begin
      wr(`VMDC_OFF_EMERG_RAMP, {p[1:0], p[1:0], 4'h0});
      cyc(3);
      chk(vol, 8'h00);
      if (p[0]) power_loss_in <= 1'b1;
      else clk_err_in <= 1'b1;
      cyc(3);
      chk(mode, vmdc_pkg::VMDC_MODE_EMERG);
      n = 0;
      while (vol !== 8'hff && n < 2000) begin
        @(posedge clk_sys_in) fs_tick_in <= 1'b1;
        @(posedge clk_sys_in) fs_tick_in <= 1'b0;
        cyc(2);
        n++;
      end
      // Updates to cover 255 codes, one per 1, 2 or 4 ticks
      s = 8 >> p;
      chk(n, (p == 3) ? 0 : ((255 + s - 1) / s) << p);
      if (n >= 2000) give_verdict();
      cyc(4);
      chk(vol, 8'hff);
      clk_err_in <= 1'b0;
      power_loss_in <= 1'b0;
    end
  endtask
  initial begin
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    t_regs();
    t_dither();
    t_automute();
    t_soft();
    t_emerg();
    give_verdict();
  end
endmodule // volume_mute_dither_ctrl_tb
